// ---- hw/cmp_timer_defines.svh ----
// register offsets, field positions, reset values and timing constants for the compare timer
`ifndef CMP_TIMER_DEFINES_SVH
`define CMP_TIMER_DEFINES_SVH

`define TMR_OFF_CTRL      12'h000
`define TMR_OFF_COUNT     12'h004
`define TMR_OFF_CMP       12'h008
`define TMR_OFF_FLAG      12'h00c
`define TMR_OFF_MASK      12'h010
`define TMR_OFF_STATUS    12'h014

`define CTRL_CS_LSB       0
`define CTRL_WGM_LSB      3
`define CTRL_COM_LSB      5
`define CTRL_FOC_BIT      7
`define CTRL_DIR_BIT      8
`define CTRL_GIE_BIT      9

`define FLAG_OVF_BIT      0
`define FLAG_CMP_BIT      1

`define STAT_OC_BIT       0
`define STAT_DOWN_BIT     1

`define CTRL_RESET        32'h0000_0000
`define COUNT_BOTTOM      8'h00
`define COUNT_MAX         8'hff

`define PRE_DIV_8         10'h007
`define PRE_DIV_64        10'h03f
`define PRE_DIV_256       10'h0ff
`define PRE_DIV_1024      10'h3ff

`endif

// ---- hw/cmp_timer_pkg.sv ----
// types shared by the compare timer
package cmp_timer_pkg;

  typedef enum logic [2:0] {
    CS_OFF, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
  } clock_select_t;

  typedef enum logic [1:0] {
    WGM_NORMAL, WGM_PHASE_PWM, WGM_CTC, WGM_FAST_PWM
  } waveform_mode_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// ---- hw/cmp_timer.sv ----
// eight-bit timer/counter with one compare channel and an apb register slave
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cmp_timer_defines.svh"

module cmp_timer (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RSTN,
  input  wire cmp_timer_pkg::apb_req_t APB_REQ,
  output var  cmp_timer_pkg::apb_rsp_t APB_RSP,
  input  wire logic                    EVENT_CLOCK_PIN,
  input  wire logic                    PIN_DIR_OUT,
  input  wire logic                    OVF_IRQ_ACK,
  input  wire logic                    CMP_IRQ_ACK,
  output logic                         COMPARE_OUTPUT,
  output logic                         COMPARE_OUTPUT_OE,
  output logic                         OVF_IRQ,
  output logic                         CMP_IRQ
);
  import cmp_timer_pkg::*;

  logic [31:0]    ctrl_q;
  logic [7:0]     count_value_q;
  logic [7:0]     compare_value_q;
  logic [7:0]     compare_buf_q;
  logic [1:0]     timer_flag_q;
  logic [1:0]     timer_irq_mask_q;
  logic           down_q;
  logic           oc_q;
  logic           block_q;
  logic [9:0]     pre_q;
  logic           ev_s1_q;
  logic           ev_s2_q;
  logic           ev_s3_q;
  logic           timer_tick;
  clock_select_t  clock_select;
  waveform_mode_t waveform_mode;
  logic [1:0]     compare_output_mode;
  logic           pwm_mode;
  logic           wr_acc;
  logic           rd_acc;
  logic           wr_count;
  logic           wr_cmp;
  logic           wr_flag;
  logic           wr_ctrl;
  logic           force_cmp;
  logic [1:0]     force_com;
  logic           wr_mask;
  logic           ovf_set;
  logic           ovf_clr;
  logic           cmp_set;
  logic           cmp_clr;
  logic           bottom;
  logic           max;
  logic           match;
  logic [7:0]     top;
  logic [7:0]     count_d;
  logic           down_d;
  logic           ovf_evt;
  logic [31:0]    rdata_d;
  logic           mapped;

  assign clock_select        = clock_select_t'(ctrl_q[`CTRL_CS_LSB +: 3]);
  assign waveform_mode       = waveform_mode_t'(ctrl_q[`CTRL_WGM_LSB +: 2]);
  assign compare_output_mode = ctrl_q[`CTRL_COM_LSB +: 2];
  assign pwm_mode            = (waveform_mode == WGM_PHASE_PWM) || (waveform_mode == WGM_FAST_PWM);

  // apb decode; slave answers with zero wait states
  assign wr_acc    = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign rd_acc    = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite;
  assign wr_ctrl   = wr_acc && (APB_REQ.paddr == `TMR_OFF_CTRL);
  assign wr_count  = wr_acc && (APB_REQ.paddr == `TMR_OFF_COUNT);
  assign wr_cmp    = wr_acc && (APB_REQ.paddr == `TMR_OFF_CMP);
  assign wr_flag   = wr_acc && (APB_REQ.paddr == `TMR_OFF_FLAG);
  assign wr_mask   = wr_acc && (APB_REQ.paddr == `TMR_OFF_MASK);
  // strobe obeys the mode and output setting written with it; odd mode codes are pwm
  assign force_com = APB_REQ.pwdata[`CTRL_COM_LSB +: 2];
  assign force_cmp = wr_ctrl && APB_REQ.pwdata[`CTRL_FOC_BIT] && !APB_REQ.pwdata[`CTRL_WGM_LSB];

  // free-running prescaler, never reset by clock select
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // event pin: two sync stages, third stage for edge detection
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
    end else begin
      ev_s1_q <= EVENT_CLOCK_PIN;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  always_comb begin
    case (clock_select)
      CS_OFF:      timer_tick = 1'b0;
      CS_DIV1:     timer_tick = 1'b1;
      CS_DIV8:     timer_tick = ((pre_q & `PRE_DIV_8) == `PRE_DIV_8);
      CS_DIV64:    timer_tick = ((pre_q & `PRE_DIV_64) == `PRE_DIV_64);
      CS_DIV256:   timer_tick = ((pre_q & `PRE_DIV_256) == `PRE_DIV_256);
      CS_DIV1024:  timer_tick = (pre_q == `PRE_DIV_1024);
      CS_EXT_FALL: timer_tick = !ev_s2_q && ev_s3_q;
      CS_EXT_RISE: timer_tick = ev_s2_q && !ev_s3_q;
      default:     timer_tick = 1'b0;
    endcase
  end

  assign bottom = (count_value_q == `COUNT_BOTTOM);
  assign max    = (count_value_q == `COUNT_MAX);
  assign top    = (waveform_mode == WGM_CTC) ? compare_value_q : `COUNT_MAX;
  // a counter write masks matches until the next tick has passed
  assign match  = (count_value_q == compare_value_q) && !block_q;

  always_comb begin
    count_d = count_value_q;
    down_d  = down_q;
    ovf_evt = 1'b0;
    case (waveform_mode)
      WGM_NORMAL: begin
        count_d = count_value_q + 8'h01;
        ovf_evt = max;
      end
      WGM_CTC: begin
        count_d = (count_value_q == top) ? `COUNT_BOTTOM : count_value_q + 8'h01;
        ovf_evt = max;
      end
      WGM_FAST_PWM: begin
        count_d = max ? `COUNT_BOTTOM : count_value_q + 8'h01;
        ovf_evt = max;
      end
      WGM_PHASE_PWM: begin
        if (max) begin
          down_d = 1'b1;
        end else if (bottom) begin
          down_d = 1'b0;
        end
        count_d = down_d ? count_value_q - 8'h01 : count_value_q + 8'h01;
        ovf_evt = bottom && down_q;
      end
      default: begin
        count_d = count_value_q;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      count_value_q <= `COUNT_BOTTOM;
      down_q        <= 1'b0;
    end else if (wr_count) begin
      count_value_q <= APB_REQ.pwdata[7:0];
    end else if (timer_tick) begin
      count_value_q <= count_d;
      down_q        <= down_d;
    end else if (!pwm_mode) begin
      down_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (timer_tick) begin
      block_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      compare_value_q <= `COUNT_BOTTOM;
      compare_buf_q   <= `COUNT_BOTTOM;
    end else begin
      if (wr_cmp) begin
        compare_buf_q <= APB_REQ.pwdata[7:0];
      end
      if (wr_cmp && !pwm_mode) begin
        compare_value_q <= APB_REQ.pwdata[7:0];
      end else if (pwm_mode && timer_tick && (max || (waveform_mode == WGM_FAST_PWM && bottom))) begin
        compare_value_q <= compare_buf_q;
      end
    end
  end

  assign ovf_set = timer_tick && ovf_evt;
  assign ovf_clr = OVF_IRQ_ACK || (wr_flag && APB_REQ.pwdata[`FLAG_OVF_BIT]);
  assign cmp_set = timer_tick && match;
  assign cmp_clr = CMP_IRQ_ACK || (wr_flag && APB_REQ.pwdata[`FLAG_CMP_BIT]);

  // hardware set wins over software or acknowledge clear, so no event is lost
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      timer_flag_q <= 2'b00;
    end else begin
      if (ovf_set) begin
        timer_flag_q[`FLAG_OVF_BIT] <= 1'b1;
      end else if (ovf_clr) begin
        timer_flag_q[`FLAG_OVF_BIT] <= 1'b0;
      end
      if (cmp_set) begin
        timer_flag_q[`FLAG_CMP_BIT] <= 1'b1;
      end else if (cmp_clr) begin
        timer_flag_q[`FLAG_CMP_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= APB_REQ.pwdata & 32'h0000_037f; // force bit reads as zero
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      timer_irq_mask_q <= 2'b00;
    end else if (wr_mask) begin
      timer_irq_mask_q <= APB_REQ.pwdata[1:0];
    end
  end

  // compare output state; survives mode changes, cleared by reset, changed by a forced compare, a compare match or count max in fast pwm
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      oc_q <= 1'b0;
    end else if (force_cmp) begin
      case (force_com)
        2'h1:    oc_q <= !oc_q;
        2'h2:    oc_q <= 1'b0;
        2'h3:    oc_q <= 1'b1;
        default: oc_q <= oc_q;
      endcase
    end else if (timer_tick && compare_output_mode != 2'h0) begin
      case (waveform_mode)
        WGM_NORMAL, WGM_CTC: begin
          if (match) begin
            oc_q <= (compare_output_mode == 2'h1) ? !oc_q : compare_output_mode[0];
          end
        end
        WGM_FAST_PWM: begin
          if (match) begin
            oc_q <= compare_output_mode[0];
          end else if (max) begin
            oc_q <= !compare_output_mode[0];
          end
        end
        WGM_PHASE_PWM: begin
          if (match) begin
            oc_q <= down_q ? !compare_output_mode[0] : compare_output_mode[0];
          end
        end
        default: oc_q <= oc_q;
      endcase
    end
  end

  assign mapped = (APB_REQ.paddr <= `TMR_OFF_STATUS) && (APB_REQ.paddr[1:0] == 2'b00);

  // captured in the setup cycle, stands through the access cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (APB_REQ.paddr)
      `TMR_OFF_CTRL:   rdata_d = ctrl_q;
      `TMR_OFF_COUNT:  rdata_d = {24'h000000, count_value_q};
      `TMR_OFF_CMP:    rdata_d = {24'h000000, pwm_mode ? compare_buf_q : compare_value_q};
      `TMR_OFF_FLAG:   rdata_d = {30'h0, timer_flag_q};
      `TMR_OFF_MASK:   rdata_d = {30'h0, timer_irq_mask_q};
      `TMR_OFF_STATUS: rdata_d = {30'h0, down_q, oc_q};
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      APB_RSP <= '0;
    end else begin
      APB_RSP.prdata  <= rd_acc ? rdata_d : 32'h0000_0000;
      APB_RSP.pready  <= 1'b1;
      APB_RSP.pslverr <= 1'b0;
      if (APB_REQ.psel && !APB_REQ.penable) begin
        APB_RSP.prdata  <= APB_REQ.pwrite ? 32'h0000_0000 : rdata_d;
        APB_RSP.pslverr <= !mapped;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      COMPARE_OUTPUT    <= 1'b0;
      COMPARE_OUTPUT_OE <= 1'b0;
      OVF_IRQ           <= 1'b0;
      CMP_IRQ           <= 1'b0;
    end else begin
      COMPARE_OUTPUT    <= oc_q;
      COMPARE_OUTPUT_OE <= (compare_output_mode != 2'h0) && PIN_DIR_OUT;
      OVF_IRQ <= timer_flag_q[`FLAG_OVF_BIT] && timer_irq_mask_q[`FLAG_OVF_BIT] && ctrl_q[`CTRL_GIE_BIT];
      CMP_IRQ <= timer_flag_q[`FLAG_CMP_BIT] && timer_irq_mask_q[`FLAG_CMP_BIT] && ctrl_q[`CTRL_GIE_BIT];
    end
  end

endmodule
`default_nettype wire

// ---- tb/cmp_timer_assertions.sv ----
// port-level checker for the compare timer
`timescale 1ns/100ps
`default_nettype none
`include "cmp_timer_defines.svh"
module cmp_timer_assertions (
  input wire logic                    CORE_CLK,
  input wire logic                    RSTN,
  input wire cmp_timer_pkg::apb_req_t APB_REQ,
  input wire cmp_timer_pkg::apb_rsp_t APB_RSP,
  input wire logic                    EVENT_CLOCK_PIN,
  input wire logic                    PIN_DIR_OUT,
  input wire logic                    OVF_IRQ_ACK,
  input wire logic                    CMP_IRQ_ACK,
  input wire logic                    COMPARE_OUTPUT,
  input wire logic                    COMPARE_OUTPUT_OE,
  input wire logic                    OVF_IRQ,
  input wire logic                    CMP_IRQ
);
  import cmp_timer_pkg::*;
  logic       acc;
  logic       rd;
  logic       wr;
  logic [9:0] ctrl_q;
  logic [1:0] mask_q;
  logic [7:0] cnt_q;
  logic [7:0] cmp_q;
  logic       frz_q;
  assign acc = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready;
  assign rd  = acc && !APB_REQ.pwrite;
  assign wr  = acc && APB_REQ.pwrite;
  // shadow of what software last wrote; force strobe never stored
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q <= '0;
      mask_q <= '0;
      cnt_q  <= '0;
      cmp_q  <= '0;
    end else if (wr) begin
      case (APB_REQ.paddr)
        `TMR_OFF_CTRL:  ctrl_q <= APB_REQ.pwdata[9:0] & 10'h37f;
        `TMR_OFF_COUNT: cnt_q <= APB_REQ.pwdata[7:0];
        `TMR_OFF_CMP:   cmp_q <= APB_REQ.pwdata[7:0];
        `TMR_OFF_MASK:  mask_q <= APB_REQ.pwdata[1:0];
        default: ;
      endcase
    end
  end
  // count only predictable while no tick source has run since the write
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) frz_q <= 1'b0;
    else if (ctrl_q[2:0] != 3'h0) frz_q <= 1'b0;
    else if (wr && APB_REQ.paddr == `TMR_OFF_COUNT) frz_q <= 1'b1;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  sequence ack_idle;
    CMP_IRQ_ACK && ctrl_q[2:0] == 3'h0 ##1 ctrl_q[2:0] == 3'h0;
  endsequence
  sequence ovf_ack_idle;
    OVF_IRQ_ACK && ctrl_q[2:0] == 3'h0 ##1 ctrl_q[2:0] == 3'h0;
  endsequence
  a_ctrl_back: assert property (
    rd && APB_REQ.paddr == `TMR_OFF_CTRL |-> APB_RSP.prdata[9:0] == ctrl_q) else $error("control readback");
  a_count_back: assert property (
    rd && APB_REQ.paddr == `TMR_OFF_COUNT && frz_q |-> APB_RSP.prdata[7:0] == cnt_q) else $error("count readback");
  a_cmp_back: assert property (
    rd && APB_REQ.paddr == `TMR_OFF_CMP |-> APB_RSP.prdata[7:0] == cmp_q) else $error("compare readback");
  a_pin_enable: assert property (
    COMPARE_OUTPUT_OE == $past(ctrl_q[6:5] != 2'h0 && PIN_DIR_OUT)) else $error("pin enable");
  a_cmp_gate: assert property (
    CMP_IRQ |-> $past(ctrl_q[9] && mask_q[1])) else $error("compare irq ungated");
  a_ovf_gate: assert property (
    OVF_IRQ |-> $past(ctrl_q[9] && mask_q[0])) else $error("overflow irq ungated");
  a_ack_clears: assert property (
    ack_idle |=> !CMP_IRQ) else $error("ack left irq");
  a_bad_addr: assert property (
    acc && APB_REQ.paddr > `TMR_OFF_STATUS |-> APB_RSP.pslverr) else $error("unmapped not refused");
  a_ovf_ack: assert property (
    ovf_ack_idle |=> !OVF_IRQ) else $error("ack left overflow irq");
  a_oc_frozen: assert property (
    !$past(wr, 2) && $past(ctrl_q[2:0], 2) == 3'h0 |-> $stable(COMPARE_OUTPUT)) else $error("output moved while stopped");
endmodule
bind cmp_timer cmp_timer_assertions chk (.CORE_CLK, .RSTN, .APB_REQ, .APB_RSP, .EVENT_CLOCK_PIN, .PIN_DIR_OUT,
  .OVF_IRQ_ACK, .CMP_IRQ_ACK, .COMPARE_OUTPUT, .COMPARE_OUTPUT_OE, .OVF_IRQ, .CMP_IRQ);
`default_nettype wire

// ---- tb/test_cmp_timer.sv ----
// self-checking bench for the compare timer
`timescale 1ns/100ps
`default_nettype none
`include "cmp_timer_defines.svh"
`define CHK(n, e, v) begin n_checks++; if ((v) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", n, e, v); end end
module test_cmp_timer;
  import cmp_timer_pkg::*;
  logic        CORE_CLK = 1'b0;
  logic        RSTN = 1'b0;
  apb_req_t    req = '0;
  apb_rsp_t    rsp;
  logic        ev = 1'b0;
  logic        dir = 1'b0;
  logic        oack = 1'b0;
  logic        cack = 1'b0;
  logic        oc, oe, oirq, cirq;
  logic [31:0] rdat;
  logic        rerr;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #5 CORE_CLK = ~CORE_CLK;
  cmp_timer dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .APB_REQ(req), .APB_RSP(rsp), .EVENT_CLOCK_PIN(ev),
    .PIN_DIR_OUT(dir), .OVF_IRQ_ACK(oack), .CMP_IRQ_ACK(cack), .COMPARE_OUTPUT(oc),
    .COMPARE_OUTPUT_OE(oe), .OVF_IRQ(oirq), .CMP_IRQ(cirq));
  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // request held until ready is seen at an edge, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge CORE_CLK);
    req.penable <= 1'b1;
    do @(posedge CORE_CLK); while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up;
    end
  end
  initial begin
    wt(3);
    RSTN <= 1'b1;
    apb(0, `TMR_OFF_STATUS, 0);
    `CHK("oc at reset", 1'b0, rdat[0])
    apb(1, `TMR_OFF_COUNT, 32'h5a);
    apb(0, `TMR_OFF_COUNT, 0);
    `CHK("count", 8'h5a, rdat[7:0])
    apb(1, `TMR_OFF_CMP, 32'ha5);
    apb(0, `TMR_OFF_CMP, 0);
    `CHK("compare", 8'ha5, rdat[7:0])
    apb(0, 12'h018, 0);
    `CHK("unmapped", 1'b1, rerr)
    apb(1, `TMR_OFF_COUNT, 32'hfe);
    apb(1, `TMR_OFF_CTRL, 32'h001);
    wt(4);
    apb(1, `TMR_OFF_CTRL, 32'h000);
    apb(0, `TMR_OFF_FLAG, 0);
    `CHK("wrap flags", 2'b01, rdat[1:0])
    apb(1, `TMR_OFF_MASK, 32'h3);
    apb(1, `TMR_OFF_CTRL, 32'h200);
    wt(2);
    `CHK("ovf irq", 1'b1, oirq)
    oack <= 1'b1;
    wt(1);
    oack <= 1'b0;
    wt(2);
    `CHK("ovf serviced", 1'b0, oirq)
    apb(1, `TMR_OFF_CMP, 32'h3);
    apb(1, `TMR_OFF_COUNT, 32'h0);
    apb(1, `TMR_OFF_CTRL, 32'h211);
    wt(20);
    apb(1, `TMR_OFF_CTRL, 32'h210);
    apb(0, `TMR_OFF_COUNT, 0);
    `CHK("ctc top", 1'b1, rdat[7:0] <= 8'h3)
    apb(0, `TMR_OFF_FLAG, 0);
    `CHK("ctc flags", 2'b10, rdat[1:0])
    `CHK("cmp irq", 1'b1, cirq)
    cack <= 1'b1;
    wt(1);
    cack <= 1'b0;
    wt(2);
    `CHK("cmp serviced", 1'b0, cirq)
    apb(1, `TMR_OFF_CTRL, 32'h011);
    wt(8);
    apb(1, `TMR_OFF_CTRL, 32'h010);
    apb(1, `TMR_OFF_FLAG, 32'h2);
    apb(0, `TMR_OFF_FLAG, 0);
    `CHK("write one clear", 2'b00, rdat[1:0])
    apb(1, `TMR_OFF_CTRL, 32'h000);
    apb(1, `TMR_OFF_CMP, 32'h10);
    apb(1, `TMR_OFF_COUNT, 32'h10);
    apb(1, `TMR_OFF_CTRL, 32'h001);
    wt(3);
    apb(1, `TMR_OFF_CTRL, 32'h000);
    apb(0, `TMR_OFF_FLAG, 0);
    `CHK("blocked match", 2'b00, rdat[1:0])
    apb(1, `TMR_OFF_CTRL, 32'h0a0);
    apb(0, `TMR_OFF_STATUS, 0);
    `CHK("forced oc", 1'b1, rdat[0])
    apb(0, `TMR_OFF_FLAG, 0);
    `CHK("force flags", 2'b00, rdat[1:0])
    apb(0, `TMR_OFF_CTRL, 0);
    `CHK("ctrl", 10'h020, rdat[9:0])
    dir <= 1'b1;
    wt(2);
    `CHK("pin", 2'b11, {oe, oc})
    apb(1, `TMR_OFF_CTRL, 32'h038);
    apb(0, `TMR_OFF_STATUS, 0);
    `CHK("oc kept", 1'b1, rdat[0])
    apb(1, `TMR_OFF_CTRL, 32'h008);
    apb(1, `TMR_OFF_CMP, 32'h40);
    apb(1, `TMR_OFF_COUNT, 32'hfd);
    apb(1, `TMR_OFF_CTRL, 32'h009);
    wt(2);
    apb(1, `TMR_OFF_CTRL, 32'h008);
    apb(0, `TMR_OFF_COUNT, 0);
    `CHK("dual slope count", 8'hfc, rdat[7:0])
    apb(0, `TMR_OFF_STATUS, 0);
    `CHK("dual slope down", 1'b1, rdat[1])
    apb(1, `TMR_OFF_CTRL, 32'h000);
    apb(0, `TMR_OFF_CMP, 0);
    `CHK("buffer loaded at top", 8'h40, rdat[7:0])
    apb(1, `TMR_OFF_CTRL, 32'h000);
    apb(1, `TMR_OFF_COUNT, 32'h0);
    apb(1, `TMR_OFF_CTRL, 32'h002);
    wt(40);
    apb(1, `TMR_OFF_CTRL, 32'h000);
    apb(0, `TMR_OFF_COUNT, 0);
    `CHK("div8", 1'b1, rdat[7:0] >= 8'h4 && rdat[7:0] <= 8'h6)
    apb(1, `TMR_OFF_COUNT, 32'h0);
    apb(1, `TMR_OFF_CTRL, 32'h007);
    // pin halves far above one core cycle so each edge is sampled
    repeat (6) begin
      wt(4);
      ev <= ~ev;
    end
    wt(6);
    apb(1, `TMR_OFF_CTRL, 32'h000);
    apb(0, `TMR_OFF_COUNT, 0);
    `CHK("events", 8'h03, rdat[7:0])
    apb(1, `TMR_OFF_COUNT, 32'h0);
    apb(1, `TMR_OFF_CTRL, 32'h006);
    repeat (4) begin
      wt(4);
      ev <= ~ev;
    end
    wt(6);
    apb(1, `TMR_OFF_CTRL, 32'h000);
    apb(0, `TMR_OFF_COUNT, 0);
    `CHK("falling events", 8'h02, rdat[7:0])
    wrap_up;
  end
endmodule
`default_nettype wire
